/* rtl/ebp_apb_decode.sv */
// address decode of the port register words
// assumes a byte address from the apb master, held through the transfer
`timescale 1ns/1ps
`default_nettype none
module ebp_apb_decode
  import ebp_pkg::*;
(
  input  wire logic [ADDR_W-1:0]   paddr,
  output logic      [NUM_REGS-1:0] sel,
  output logic                     hit
);

  always_comb begin
    sel = '0;
    unique case (paddr)
      OFS_PIN_READ:   sel[SEL_PIN_READ]   = 1'b1;
      OFS_OUT_LATCH:  sel[SEL_OUT_LATCH]  = 1'b1;
      OFS_DIRECTION:  sel[SEL_DIRECTION]  = 1'b1;
      OFS_PORT_E_DIR: sel[SEL_PORT_E_DIR] = 1'b1;
      OFS_PWM_CTRL:   sel[SEL_PWM_CTRL]   = 1'b1;
      default:        sel = '0;
    endcase
    hit = |sel;
  end

endmodule : ebp_apb_decode
`default_nettype wire

/* rtl/ebp_pin_mux.sv */
// per-pin output selection: pwm over slave port over plain port data
// assumes ownership flags already qualified by the direction bits
`timescale 1ns/1ps
`default_nettype none
module ebp_pin_mux #(
  parameter int unsigned N = 8
) (
  input  wire logic [N-1:0] latch,
  input  wire logic [N-1:0] dir,
  input  wire logic         psp_active,
  input  wire logic         psp_read_en,
  input  wire logic [N-1:0] pwm_own,
  input  wire logic [N-1:0] pwm_val,
  input  wire logic         pwm_hiz,
  output logic      [N-1:0] pin_out,
  output logic      [N-1:0] pin_oe
);

  for (genvar i = 0; i < N; i++) begin : g_pin
    always_comb begin
      if (pwm_own[i]) begin
        pin_out[i] = pwm_val[i];
        pin_oe[i]  = ~pwm_hiz;
      end else if (psp_active) begin
        // direction bits are ignored while the slave port owns the pins
        pin_out[i] = latch[i];
        pin_oe[i]  = psp_read_en;
      end else begin
        pin_out[i] = latch[i];
        pin_oe[i]  = ~dir[i];
      end
    end
  end

endmodule : ebp_pin_mux
`default_nettype wire

/* rtl/ebp_pkg.sv */
// constants, field layout and reset state of the eight-pin port block
// assumes a 32-bit apb master and pins sampled on pclk
package ebp_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned PORT_W = 8;
  localparam int unsigned NUM_REGS = 5;

  // byte offsets, one aligned word each
  localparam logic [ADDR_W-1:0] OFS_PIN_READ    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OUT_LATCH   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DIRECTION   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PORT_E_DIR  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_PWM_CTRL    = 8'h10;

  // one-hot select positions
  localparam int unsigned SEL_PIN_READ   = 0;
  localparam int unsigned SEL_OUT_LATCH  = 1;
  localparam int unsigned SEL_DIRECTION  = 2;
  localparam int unsigned SEL_PORT_E_DIR = 3;
  localparam int unsigned SEL_PWM_CTRL   = 4;

  // port_e_direction fields
  localparam int unsigned PE_DIR_LSB     = 0;
  localparam int unsigned PE_DIR_W       = 3;
  localparam int unsigned PE_SLAVE_BIT   = 4;

  // pwm control fields
  localparam int unsigned PWM_EN_BIT     = 0;
  localparam int unsigned PWM_MODE_LSB   = 2;
  localparam int unsigned PWM_SD_TRI_BIT = 4;

  localparam logic [1:0] PWM_MODE_SINGLE   = 2'h0;
  localparam logic [1:0] PWM_MODE_QUAD_FWD = 2'h1;
  localparam logic [1:0] PWM_MODE_DUAL     = 2'h2;
  localparam logic [1:0] PWM_MODE_QUAD_REV = 2'h3;

  // pins taken over by pwm channels b, c, d
  localparam int unsigned PWM_B_PIN = 5;
  localparam int unsigned PWM_C_PIN = 6;
  localparam int unsigned PWM_D_PIN = 7;

  localparam logic [PORT_W-1:0]   LATCH_RST  = 8'h00;
  localparam logic [PORT_W-1:0]   DIR_RST    = 8'hff;
  localparam logic [PE_DIR_W-1:0] PE_DIR_RST = 3'h7;

  typedef struct packed {
    logic [PORT_W-1:0]   latch;
    logic [PORT_W-1:0]   dir;
    logic [PE_DIR_W-1:0] pe_dir;
    logic                slave_sel;
    logic                pwm_en;
    logic [1:0]          pwm_mode;
    logic                sd_tri;
    logic [DATA_W-1:0]   rdata;
    logic                slverr;
    logic [PORT_W-1:0]   psp_wdata;
  } ebp_state_s;

  localparam ebp_state_s STATE_RST = '{
    latch:     LATCH_RST,
    dir:       DIR_RST,
    pe_dir:    PE_DIR_RST,
    slave_sel: 1'b0,
    pwm_en:    1'b0,
    pwm_mode:  PWM_MODE_SINGLE,
    sd_tri:    1'b0,
    rdata:     32'h0000_0000,
    slverr:    1'b0,
    psp_wdata: 8'h00
  };

endpackage : ebp_pkg

/* rtl/ebp_port.sv */
// eight-pin port with direction, output latch, pin read, slave mode and pwm takeover
// assumes an apb master on pclk and pin levels already synchronous to pclk
//
// What this block does
// R1 - eight pins, each with direction, latch, read bit
// R2 - direction one puts a general-purpose pin's driver off
// R3 - direction zero drives a general-purpose pin from latch
// R4 - latch readable and writable, returns latched values
// R5 - every pin's direction set independently
// R6 - pins come out of reset as inputs
// R7 - slave-select bit turns port into slave port
// R8 - slave mode drives latch, takes writes, ignores direction
// R9 - dual or quad pwm disables slave mode
// R10 - pwm b, c, d own upper pins
// R11 - pwm pins may float during shutdown
// R12 - slave-select one is slave, zero general, resets zero
// R13 - pin-read returns pins, write goes to latch
`timescale 1ns/1ps
`default_nettype none
module ebp_port
  import ebp_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [PORT_W-1:0] pin_in,
  output logic      [PORT_W-1:0] pin_out,
  output logic      [PORT_W-1:0] pin_oe,
  input  wire logic              psp_read_en,
  input  wire logic              psp_write_en,
  output logic      [PORT_W-1:0] psp_write_data,
  output logic                   slave_port_active,
  input  wire logic              pwm_channel_b,
  input  wire logic              pwm_channel_c,
  input  wire logic              pwm_channel_d,
  input  wire logic              pwm_shutdown,
  output logic      [PE_DIR_W-1:0] port_e_direction
);

  ebp_state_s s_r;
  ebp_state_s s_nxt;

  logic [NUM_REGS-1:0] sel;
  logic                hit;
  logic                setup_ph;
  logic                wr_acc;
  logic [DATA_W-1:0]   rd_word;
  logic                pwm_dual_quad;
  logic                pwm_quad;
  logic                psp_active;
  logic [PORT_W-1:0]   pwm_own;
  logic [PORT_W-1:0]   pwm_val;
  logic                pwm_hiz;

  ebp_apb_decode u_decode (
    .paddr (paddr),
    .sel   (sel),
    .hit   (hit)
  );

  // no wait states: every access completes in its first access cycle
  assign pready   = 1'b1;
  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite & hit;

  // read word is built in the setup cycle so prdata comes from a flop
  always_comb begin
    rd_word = '0;
    if (sel[SEL_PIN_READ]) begin
      rd_word[PORT_W-1:0] = pin_in; // [R13]
    end
    if (sel[SEL_OUT_LATCH]) begin
      rd_word[PORT_W-1:0] = s_r.latch; // [R4]
    end
    if (sel[SEL_DIRECTION]) begin
      rd_word[PORT_W-1:0] = s_r.dir;
    end
    if (sel[SEL_PORT_E_DIR]) begin
      // buffer flags of the slave handshake live elsewhere and read zero here
      rd_word[PE_DIR_LSB +: PE_DIR_W] = s_r.pe_dir;
      rd_word[PE_SLAVE_BIT]           = s_r.slave_sel;
    end
    if (sel[SEL_PWM_CTRL]) begin
      rd_word[PWM_EN_BIT]          = s_r.pwm_en;
      rd_word[PWM_MODE_LSB +: 2]   = s_r.pwm_mode;
      rd_word[PWM_SD_TRI_BIT]      = s_r.sd_tri;
    end
  end

  // pwm ownership of the upper pins
  always_comb begin
    pwm_dual_quad = s_r.pwm_en & (s_r.pwm_mode != PWM_MODE_SINGLE);
    pwm_quad      = s_r.pwm_en & ((s_r.pwm_mode == PWM_MODE_QUAD_FWD) |
                                  (s_r.pwm_mode == PWM_MODE_QUAD_REV));
    pwm_own            = '0;
    pwm_val            = '0;
    pwm_own[PWM_B_PIN] = pwm_dual_quad & ~s_r.dir[PWM_B_PIN]; // [R10]
    pwm_own[PWM_C_PIN] = pwm_quad & ~s_r.dir[PWM_C_PIN]; // [R10]
    pwm_own[PWM_D_PIN] = pwm_quad & ~s_r.dir[PWM_D_PIN]; // [R10]
    pwm_val[PWM_B_PIN] = pwm_channel_b;
    pwm_val[PWM_C_PIN] = pwm_channel_c;
    pwm_val[PWM_D_PIN] = pwm_channel_d;
    pwm_hiz            = s_r.sd_tri & pwm_shutdown; // [R11]
  end

  // dual or quad pwm silently takes the slave port away
  assign psp_active = s_r.slave_sel & ~pwm_dual_quad; // [R7] [R9] [R12]

  always_comb begin
    s_nxt = s_r;
    if (setup_ph) begin
      s_nxt.rdata  = pwrite ? '0 : rd_word;
      s_nxt.slverr = ~hit;
    end
    if (wr_acc) begin
      if (sel[SEL_PIN_READ] | sel[SEL_OUT_LATCH]) begin
        s_nxt.latch = pwdata[PORT_W-1:0]; // [R4] [R13]
      end
      if (sel[SEL_DIRECTION]) begin
        s_nxt.dir = pwdata[PORT_W-1:0]; // [R5]
      end
      if (sel[SEL_PORT_E_DIR]) begin
        s_nxt.pe_dir    = pwdata[PE_DIR_LSB +: PE_DIR_W];
        s_nxt.slave_sel = pwdata[PE_SLAVE_BIT]; // [R12]
      end
      if (sel[SEL_PWM_CTRL]) begin
        s_nxt.pwm_en   = pwdata[PWM_EN_BIT];
        s_nxt.pwm_mode = pwdata[PWM_MODE_LSB +: 2];
        s_nxt.sd_tri   = pwdata[PWM_SD_TRI_BIT];
      end
    end
    // slave write data is taken from the pins whatever the direction bits say
    if (psp_active & psp_write_en) begin
      s_nxt.psp_wdata = pin_in; // [R8]
    end
  end

  // reset leaves every direction bit set, so all pins start as inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= STATE_RST; // [R6] [R12]
    end else begin
      s_r <= s_nxt;
    end
  end

  ebp_pin_mux #(
    .N (PORT_W)
  ) u_mux (
    .latch       (s_r.latch),
    .dir         (s_r.dir),
    .psp_active  (psp_active),
    .psp_read_en (psp_read_en),
    .pwm_own     (pwm_own),
    .pwm_val     (pwm_val),
    .pwm_hiz     (pwm_hiz),
    .pin_out     (pin_out),
    .pin_oe      (pin_oe)
  ); // [R1] [R2] [R3] [R8]

  assign prdata            = s_r.rdata;
  assign pslverr           = s_r.slverr;
  assign psp_write_data    = s_r.psp_wdata;
  assign slave_port_active = psp_active;
  assign port_e_direction  = s_r.pe_dir;

  // checks

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [PORT_W-1:0] gp_pins;
  assign gp_pins = (psp_active ? '0 : ~pwm_own);

  sequence apb_write_s(logic [ADDR_W-1:0] a);
    psel && !penable && pwrite && (paddr == a) ##1 psel && penable && pwrite && (paddr == a);
  endsequence

  sequence apb_read_setup_s(logic [ADDR_W-1:0] a);
    psel && !penable && !pwrite && (paddr == a);
  endsequence

  sequence slave_write_s;
    psp_active && psp_write_en;
  endsequence

  // general-purpose pins with direction one never drive
  dir_input_hiz_a: assert property ( // [R2]
    (pin_oe & gp_pins & s_r.dir) == '0
  ) else $error("input pin is being driven");

  // general-purpose pins with direction zero drive the latch
  dir_output_drive_a: assert property ( // [R3]
    ((pin_oe & gp_pins & ~s_r.dir) == (gp_pins & ~s_r.dir)) &&
    ((pin_out & gp_pins & ~s_r.dir) == (s_r.latch & gp_pins & ~s_r.dir))
  ) else $error("output pin does not follow latch");

  // latch write then latch read returns the written byte
  latch_readback_a: assert property ( // [R4]
    apb_write_s(OFS_OUT_LATCH) ##[1:2] apb_read_setup_s(OFS_OUT_LATCH) |=>
      prdata == {24'h000000, $past(s_r.latch)}
  ) else $error("latch read does not return latched value");

  // pin-read register returns pin levels seen at setup
  pin_read_a: assert property ( // [R13]
    apb_read_setup_s(OFS_PIN_READ) |=> (prdata[PORT_W-1:0] == $past(pin_in)) && !pslverr
  ) else $error("pin read does not return pin levels");

  // a write to the pin-read register lands in the latch
  pin_write_latch_a: assert property ( // [R13]
    apb_write_s(OFS_PIN_READ) |=> s_r.latch == $past(pwdata[PORT_W-1:0])
  ) else $error("pin-read write did not reach latch");

  // each direction bit is written as given, with no coupling
  dir_indep_a: assert property ( // [R5]
    apb_write_s(OFS_DIRECTION) |=> s_r.dir == $past(pwdata[PORT_W-1:0])
  ) else $error("direction write not stored bit for bit");

  // slave select written one, with no dual/quad pwm, enables slave mode
  mode_select_a: assert property ( // [R12]
    apb_write_s(OFS_PORT_E_DIR) ##0 (!pwm_dual_quad) |=>
      (s_r.slave_sel == $past(pwdata[PE_SLAVE_BIT])) && (psp_active == $past(pwdata[PE_SLAVE_BIT]))
  ) else $error("slave select does not follow write");

  // slave mode drives the latch on non-pwm pins during a read strobe
  psp_drive_a: assert property ( // [R8]
    psp_active && psp_read_en |->
      ((pin_oe & ~pwm_own) == ~pwm_own) && ((pin_out & ~pwm_own) == (s_r.latch & ~pwm_own))
  ) else $error("slave read does not drive latch");

  // slave write data is captured one cycle later
  psp_capture_a: assert property ( // [R8]
    slave_write_s |=> psp_write_data == $past(pin_in)
  ) else $error("slave write data not captured");

  // dual or quad pwm always masks the slave port
  psp_block_a: assert property ( // [R9]
    pwm_dual_quad |-> !psp_active && !slave_port_active
  ) else $error("slave port active with dual or quad pwm");

  // an owned pwm b pin carries the channel b value
  pwm_prio_a: assert property ( // [R10]
    pwm_own[PWM_B_PIN] && !pwm_hiz |->
      pin_oe[PWM_B_PIN] && (pin_out[PWM_B_PIN] == pwm_channel_b)
  ) else $error("pwm channel b lost pin priority");

  pwm_quad_prio_a: assert property ( // [R10]
    pwm_quad && !s_r.dir[PWM_D_PIN] && !pwm_hiz |->
      pin_oe[PWM_D_PIN] && (pin_out[PWM_D_PIN] == pwm_channel_d)
  ) else $error("pwm channel d lost pin priority");

  // shutdown with tri-state enabled floats every owned pwm pin
  pwm_tristate_a: assert property ( // [R11]
    s_r.sd_tri && pwm_shutdown |-> (pin_oe & pwm_own) == '0
  ) else $error("pwm pin driven during shutdown");

  // unmapped address answers with an error in the access cycle
  unmapped_err_a: assert property ( // [R1]
    psel && !penable && !hit |=> pslverr && pready
  ) else $error("unmapped access not flagged");

  // right after reset release the port holds all pins as inputs
  reset_inputs_a: assert property ( // [R6]
    $rose(presetn) |-> (s_r.dir == DIR_RST) && (pin_oe == '0) && !psp_active
  ) else $error("port not all inputs after reset");

  sequence pwm_float_s;
    s_r.sd_tri && pwm_shutdown;
  endsequence

  // every read answers at once with the upper data bits at zero
  read_upper_zero_a: assert property ( // [R1]
    psel && penable && !pwrite |-> pready && (prdata[DATA_W-1:PORT_W] == '0)
  ) else $error("upper read bits not zero");

  // a mapped address never answers with an error
  mapped_ok_a: assert property ( // [R1]
    psel && !penable && hit |=> !pslverr
  ) else $error("mapped access flagged as error");

  // latch write stores the low byte
  latch_write_a: assert property ( // [R4]
    apb_write_s(OFS_OUT_LATCH) |=> s_r.latch == $past(pwdata[PORT_W-1:0])
  ) else $error("latch write not stored");

  // without a latch write the latch keeps its value
  latch_hold_a: assert property ( // [R4]
    !(wr_acc && (sel[SEL_PIN_READ] || sel[SEL_OUT_LATCH])) |=> $stable(s_r.latch)
  ) else $error("latch changed without a write");

  // writes to unmapped places leave the port alone
  unmapped_wr_a: assert property ( // [R4]
    psel && penable && pwrite && !hit |=>
      $stable(s_r.latch) && $stable(s_r.dir) && $stable(s_r.slave_sel)
  ) else $error("unmapped write changed state");

  // direction read returns the stored bits
  dir_read_a: assert property ( // [R5]
    apb_read_setup_s(OFS_DIRECTION) |=> prdata[PORT_W-1:0] == $past(s_r.dir)
  ) else $error("direction read mismatch");

  // other port's direction bits follow their write
  port_e_write_a: assert property ( // [R7]
    apb_write_s(OFS_PORT_E_DIR) |=> port_e_direction == $past(pwdata[PE_DIR_LSB +: PE_DIR_W])
  ) else $error("port e direction write not stored");

  // slave mode without a read strobe leaves the non-pwm pins floating
  psp_float_a: assert property ( // [R8]
    psp_active && !psp_read_en |-> (pin_oe & ~pwm_own) == '0
  ) else $error("slave pins driven without read strobe");

  // a write strobe outside slave mode is ignored
  psp_refuse_a: assert property ( // [R9]
    !psp_active && psp_write_en |=> $stable(psp_write_data)
  ) else $error("slave write taken while slave port off");

  // channel c keeps its pin while owned
  pwm_c_prio_a: assert property ( // [R10]
    pwm_own[PWM_C_PIN] && !pwm_hiz |->
      pin_oe[PWM_C_PIN] && (pin_out[PWM_C_PIN] == pwm_channel_c)
  ) else $error("pwm channel c lost pin priority");

  // pwm never drives pin b while its direction bit is one
  pwm_dir_gate_a: assert property ( // [R10]
    s_r.dir[PWM_B_PIN] && !(psp_active && psp_read_en) |-> !pin_oe[PWM_B_PIN]
  ) else $error("pwm drove a pin set as input");

  // the pin is driven again once shutdown ends
  pwm_recover_a: assert property ( // [R11]
    pwm_float_s ##1 (!pwm_shutdown && pwm_own[PWM_B_PIN]) |-> pin_oe[PWM_B_PIN]
  ) else $error("pwm pin not driven after shutdown");

  // reset leaves latch cleared and slave mode off
  reset_state_a: assert property ( // [R12]
    $rose(presetn) |->
      (s_r.latch == LATCH_RST) && (port_e_direction == PE_DIR_RST) && !slave_port_active
  ) else $error("port state wrong after reset");

endmodule : ebp_port
`default_nettype wire

/* verif/ebp_board.sv */
// board model for the eight port pins: external drivers and floating lines
// assumes pin_oe/pin_out from the port; ext_en marks where the board drives
`timescale 1ns/1ps
`default_nettype none
module ebp_board
  import ebp_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic [PORT_W-1:0] pin_out,
  input  wire logic [PORT_W-1:0] pin_oe,
  input  wire logic [PORT_W-1:0] ext_val,
  input  wire logic [PORT_W-1:0] ext_en,
  output logic      [PORT_W-1:0] level,
  output logic                   clash
);
  logic [PORT_W-1:0] last_r = 8'h00;

  // an undriven line flips each cycle so a stale value never reads as good
  assign level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & ~last_r);
  assign clash = |(pin_oe & ext_en);

  always_ff @(posedge pclk) begin
    last_r <= level;
  end
endmodule : ebp_board
`default_nettype wire

/* verif/ebp_port_tb_top.sv */
// self-checking bench of the eight-pin port: registers over apb, pins via board model
// assumes zero-wait apb slave and combinational pin outputs
`timescale 1ns/1ps
`default_nettype none
module ebp_port_tb_top
  import ebp_pkg::*;
  ;
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] lat;
    logic [7:0] ext;
    logic       via_pin;
    logic [7:0] pin;
  } ebp_row_s;

  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h0, prdata;
  logic              pready, pslverr, psp_read_en = 1'b0, psp_write_en = 1'b0;
  logic [PORT_W-1:0] pin_in, pin_out, pin_oe, psp_write_data, ext_val = 8'h00, ext_en = 8'h00;
  logic              slave_port_active, clash, pwm_shutdown = 1'b0;
  logic              pwm_channel_b = 1'b0, pwm_channel_c = 1'b0, pwm_channel_d = 1'b0;
  logic [PE_DIR_W-1:0] port_e_direction;
  int                mismatches = 0;
  int                compares = 0;
  ebp_row_s          rows [5] = '{'{8'hff, 8'ha5, 8'h3c, 1'b0, 8'h3c}, '{8'h00, 8'h5a, 8'hff, 1'b0, 8'h5a},
                                  '{8'h0f, 8'hc3, 8'h96, 1'b1, 8'hc6}, '{8'hcf, 8'h81, 8'h7e, 1'b0, 8'h4e},
                                  '{8'h55, 8'haa, 8'h0f, 1'b1, 8'haf}};
  logic [7:0]        mode_oe [4] = '{8'h00, 8'he0, 8'he0, 8'he0};
  logic [2:0]        mode_up [4] = '{3'h0, 3'h2, 3'h0, 3'h2};

  always #12.5 pclk = ~pclk;

  ebp_port ebp_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .psp_read_en(psp_read_en), .psp_write_en(psp_write_en),
    .psp_write_data(psp_write_data), .slave_port_active(slave_port_active), .pwm_channel_b(pwm_channel_b),
    .pwm_channel_c(pwm_channel_c), .pwm_channel_d(pwm_channel_d), .pwm_shutdown(pwm_shutdown),
    .port_e_direction(port_e_direction));

  ebp_board ebp_board_inst (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
    .ext_en(ext_en), .level(pin_in), .clash(clash));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
                     output logic [DATA_W-1:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] rd;
    logic              er;
    apb(1'b1, a, d, rd, er);
  endtask : wr

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input logic experr);
    logic [DATA_W-1:0] rd;
    logic              er;
    apb(1'b0, a, 32'h0, rd, er);
    chk(rd, exp, "read data");
    chk(32'(er), 32'(experr), "slave error");
  endtask : rdchk

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // whole run is under two hundred cycles; generous margin
  initial begin
    #(4000 * 25);
    mismatches++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk(32'(pin_oe), 32'h0, "reset oe");
    rdchk(OFS_DIRECTION, 32'hff, 1'b0);
    rdchk(OFS_OUT_LATCH, 32'h00, 1'b0);
    rdchk(OFS_PORT_E_DIR, 32'h07, 1'b0);
    rdchk(OFS_PWM_CTRL, 32'h00, 1'b0);
    for (int i = 0; i < 5; i++) begin
      ext_en <= rows[i].dir;
      ext_val <= rows[i].ext;
      wr(OFS_DIRECTION, 32'(rows[i].dir));
      wr(rows[i].via_pin ? OFS_PIN_READ : OFS_OUT_LATCH, 32'(rows[i].lat));
      rdchk(OFS_OUT_LATCH, 32'(rows[i].lat), 1'b0);
      rdchk(OFS_DIRECTION, 32'(rows[i].dir), 1'b0);
      rdchk(OFS_PIN_READ, 32'(rows[i].pin), 1'b0);
      chk(32'(pin_oe), {24'h000000, ~rows[i].dir}, "pin oe");
      chk(32'(pin_out & ~rows[i].dir), 32'(rows[i].lat & ~rows[i].dir), "pin out");
      chk(32'(clash), 32'h0, "pin clash");
    end
    // unmapped and unaligned places refuse and leave state alone
    rdchk(8'h14, 32'h0, 1'b1);
    rdchk(8'h02, 32'h0, 1'b1);
    wr(8'h14, 32'hff);
    rdchk(OFS_OUT_LATCH, 32'haa, 1'b0);
    ext_en <= 8'h00;
    wr(OFS_DIRECTION, 32'hff);
    wr(OFS_OUT_LATCH, 32'h3c);
    wr(OFS_PORT_E_DIR, 32'h10);
    rdchk(OFS_PORT_E_DIR, 32'h10, 1'b0);
    psp_read_en <= 1'b1;
    @(negedge pclk);
    chk(32'(slave_port_active), 32'h1, "slave active");
    chk(32'(port_e_direction), 32'h0, "port e dir");
    chk(32'(pin_oe), 32'hff, "slave oe");
    chk(32'(pin_out), 32'h3c, "slave out");
    @(posedge pclk);
    psp_read_en <= 1'b0;
    ext_en <= 8'hff;
    ext_val <= 8'ha7;
    psp_write_en <= 1'b1;
    @(posedge pclk);
    psp_write_en <= 1'b0;
    @(negedge pclk);
    chk(32'(psp_write_data), 32'ha7, "slave write");
    chk(32'(pin_oe), 32'h00, "slave float");
    ext_en <= 8'h1f;
    wr(OFS_DIRECTION, 32'h1f);
    pwm_channel_c <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr(OFS_PWM_CTRL, 32'(1 | (m << 2)));
      @(negedge pclk);
      chk(32'(slave_port_active), 32'(m == 0), "mode active");
      chk(32'(pin_oe), 32'(mode_oe[m]), "mode oe");
      if (m != 0) chk(32'(pin_out[7:5]), 32'(mode_up[m]), "mode out");
    end
    // quad pwm holds the slave port off, so a write strobe must be ignored
    @(posedge pclk);
    ext_val <= 8'h5e;
    psp_write_en <= 1'b1;
    @(posedge pclk);
    psp_write_en <= 1'b0;
    @(negedge pclk);
    chk(32'(psp_write_data), 32'ha7, "refused write");
    wr(OFS_PWM_CTRL, 32'h15);
    pwm_shutdown <= 1'b1;
    @(negedge pclk);
    chk(32'(pin_oe[7:5]), 32'h0, "shutdown float");
    @(posedge pclk);
    pwm_shutdown <= 1'b0;
    @(negedge pclk);
    chk(32'(pin_oe[7:5]), 32'h7, "shutdown end");
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    chk(32'(pin_oe), 32'h0, "mid reset oe");
    chk(32'(slave_port_active), 32'h0, "mid reset slave");
    chk(32'(port_e_direction), 32'h7, "mid reset port e");
    @(posedge pclk);
    presetn <= 1'b1;
    rdchk(OFS_DIRECTION, 32'hff, 1'b0);
    print_verdict();
  end
endmodule : ebp_port_tb_top
`default_nettype wire
